// >>> verilog/cfg_fwd.sv
// Configuration transaction forwarding with one delayed transaction slot
`timescale 1ns/1ps
`default_nettype none
`include "cfg_fwd_defines.svh"

module cfg_fwd
(
    input  wire logic                   clk_i,
    input  wire logic                   reset_n_i,
    input  wire cfg_fwd_pkg::bus_nums_t bus_nums_i,
    input  wire cfg_fwd_pkg::cfg_req_t  req_i,
    output logic                        req_ready_o,
    output cfg_fwd_pkg::cfg_resp_t      resp_o,
    output cfg_fwd_pkg::cfg_issue_t     issue_o,
    input  wire cfg_fwd_pkg::cfg_cpl_t  cpl_i,
    output logic                        rx_mabort_o
);
    import cfg_fwd_pkg::*;

    state_t q;
    state_t d;

    // Decode results for the request of this cycle
    logic        dec_claim;
    port_t       dec_port;
    logic [31:0] dec_addr;
    logic [3:0]  dec_cmd;
    logic        dec_spc;

    logic [7:0]  bus;
    logic [4:0]  dev;
    logic [2:0]  func;
    logic [5:0]  regn;
    logic        is_t1;
    logic        is_cfg;
    logic        is_wr;
    logic        eq1;
    logic        eq2;
    logic        rng1;
    logic        rng2;
    logic        spc_fmt;
    logic [15:0] idsel;
    logic        same_req;

    // Address phase field split
    always_comb
    begin
        bus     = req_i.addr[`FLD_BUS];
        dev     = req_i.addr[`FLD_DEV];
        func    = req_i.addr[`FLD_FUNC];
        regn    = req_i.addr[`FLD_REG];
        is_t1   = (req_i.addr[`FLD_TYPE] == `TYPE1_CODE);
        is_wr   = (req_i.cmd == `CMD_CFG_WR);
        is_cfg  = is_wr || (req_i.cmd == `CMD_CFG_RD);
        spc_fmt = is_wr && (dev == `DEV_ALL1) && (func == `FUNC_ALL1) && (regn == `REG_ZERO);
        eq1     = (bus == bus_nums_i.s1_sec);
        eq2     = (bus == bus_nums_i.s2_sec);
        rng1    = (bus > bus_nums_i.s1_sec) && (bus <= bus_nums_i.s1_sub);  // see R09
        rng2    = (bus > bus_nums_i.s2_sec) && (bus <= bus_nums_i.s2_sub);  // see R09
    end

    // One-hot select from device number, none above 15
    always_comb
    begin
        if (dev[4])
        begin
            idsel = `IDSEL_NONE;  // see R05
        end
        else
        begin
            idsel = `IDSEL_ONE << dev[3:0];  // see R04
        end
    end

    // Forwarding decision; first port wins if ranges overlap
    always_comb
    begin
        dec_claim = 1'b0;
        dec_port  = PORT_PRI;
        dec_addr  = req_i.addr;
        dec_cmd   = req_i.cmd;
        dec_spc   = 1'b0;
        if (!req_i.valid || !is_t1 || !is_cfg)
        begin
            // Special cycle commands and Type 0 accesses stay unclaimed
            dec_claim = 1'b0;  // see R12
        end
        else if (req_i.src == PORT_PRI)
        begin
            if (eq1 || rng1 || eq2 || rng2)
            begin
                dec_claim = 1'b1;
                dec_port  = (eq1 || rng1) ? PORT_S1 : PORT_S2;  // see R18
                if ((eq1 || (!rng1 && eq2)) && spc_fmt)
                begin
                    // Address and message data untouched
                    dec_cmd = `CMD_SPECIAL;  // see R13, R14, R06
                    dec_spc = 1'b1;
                end
                else if (eq1 || (!rng1 && eq2))
                begin
                    // Type 0 form only ever heads downstream
                    dec_addr = {idsel, `DEV_CLEAR, req_i.addr[`FLD_KEEP], `TYPE0_CODE};  // see R01, R02, R03
                end
            end
        end
        else if (is_wr && (dev == `DEV_ALL1) && (func == `FUNC_ALL1))
        begin
            dec_port = PORT_PRI;
            if ((bus == bus_nums_i.pri_bus) && (regn == `REG_ZERO))
            begin
                dec_claim = 1'b1;
                dec_cmd   = `CMD_SPECIAL;  // see R13, R14
                dec_spc   = 1'b1;
            end
            else if (req_i.src == PORT_S1)
            begin
                dec_claim = (bus < bus_nums_i.s1_sec) || (bus > bus_nums_i.s1_sub);  // see R10
            end
            else
            begin
                dec_claim = (bus < bus_nums_i.s2_sec) || (bus > bus_nums_i.s2_sub);  // see R10
            end
        end
    end

    // A repeat must match the held source, address, command and, for writes, data
    always_comb
    begin
        same_req = (req_i.src == q.held.src) && (req_i.addr == q.held.addr)
                   && (req_i.cmd == q.held.cmd)
                   && ((req_i.cmd != `CMD_CFG_WR) || (req_i.data == q.held.data));  // see R17
    end

    // Next state of the single delayed transaction slot
    always_comb
    begin
        d = q;
        d.resp      = '0;
        d.rx_mabort = 1'b0;
        d.resp.valid = req_i.valid;
        unique case (q.fsm)
            ST_IDLE:
            begin
                if (dec_claim)
                begin
                    // Accept as delayed, answer retry at once
                    d.held        = req_i;  // see R08, R11
                    d.spc         = dec_spc;
                    d.issue.valid = 1'b1;
                    d.issue.port  = dec_port;
                    d.issue.addr  = dec_addr;
                    d.issue.cmd   = dec_cmd;
                    d.issue.data  = req_i.data;
                    d.resp.claim  = 1'b1;
                    d.resp.retry  = 1'b1;
                    d.fsm         = ST_ISSUE;
                end
            end
            ST_ISSUE:
            begin
                // Slot busy: every claimable access is retried
                if (dec_claim)
                begin
                    d.resp.claim = 1'b1;
                    d.resp.retry = 1'b1;
                end
                if (cpl_i.done && (cpl_i.term != END_RETRY))
                begin
                    // One data transfer only, then slot holds result
                    d.issue.valid = 1'b0;  // see R08, R11
                    d.res         = cpl_i.term;
                    d.rdata       = cpl_i.data;
                    d.fsm         = ST_HOLD;
                    // Expected abort of a special cycle is not reported
                    d.rx_mabort   = (cpl_i.term == END_MABORT) && !q.spc;  // see R15
                end
            end
            ST_HOLD:
            begin
                if (req_i.valid && same_req)
                begin
                    d.fsm = ST_IDLE;
                    if (q.spc || (q.res == END_NORMAL))
                    begin
                        // Special cycle answers with data acknowledge
                        d.resp.claim = 1'b1;  // see R15
                        d.resp.trdy  = 1'b1;
                        d.resp.disc  = q.held.multi;  // see R16, R08, R11
                        d.resp.data  = q.rdata;
                    end
                    else if (q.res == END_TABORT)
                    begin
                        d.resp.claim  = 1'b1;
                        d.resp.tabort = 1'b1;
                    end
                    else
                    begin
                        // No select line raised: abort reflected by no claim
                        d.resp.claim = 1'b0;  // see R07
                    end
                end
                else if (dec_claim)
                begin
                    d.resp.claim = 1'b1;
                    d.resp.retry = 1'b1;
                end
            end
        endcase
    end

    // All state in one register
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // Ready is tied high; other outputs come straight from the registered state
    assign req_ready_o = 1'b1;
    assign resp_o      = q.resp;
    assign issue_o     = q.issue;
    assign rx_mabort_o = q.rx_mabort;

endmodule

`default_nettype wire

// >>> verilog/cfg_fwd_defines.svh
// Constants of the configuration forwarding block
//
// Summary of operation
// R01: Type 0 form is issued only toward a secondary bus, never on primary.
// R02: Claim primary Type 1 for conversion when low bits 01 and bus equals secondary.
// R03: Converted address gets low bits 00, bits 15..11 cleared, function/register kept.
// R04: Device numbers 0..15 drive one-hot select on bit 16 plus device number.
// R05: Device numbers 16..30 drive zero upper bits, command still forwarded.
// R06: Device 31 function 7 register 0 write makes a special cycle, otherwise zero upper bits.
// R07: No select asserted means missing target answer is a master abort.
// R08: Type 1 to Type 0 reads and writes are delayed, one 32-bit transfer.
// R09: Forward Type 1 unchanged when bus above secondary and not above subordinate.
// R10: Forward write upstream when outside range and device, function all ones.
// R11: Forwarded Type 1 writes are delayed transactions with a single transfer.
// R12: Special cycles addressed to the bridge are ignored, never passed across.
// R13: Write with all-ones device/function, register 0, matching bus makes special cycle.
// R14: Special cycle replaces command, address and message data pass unchanged.
// R15: Special cycle completes on master abort; next retry gets normal acknowledge.
// R16: Multi-phase special-cycle write gets target disconnect in first data phase.
// R17: Retried initiator repeats the identical access until it completes.
// R18: Secondary port chosen by comparing bus number with each port's range.
`ifndef CFG_FWD_DEFINES_SVH
`define CFG_FWD_DEFINES_SVH

// Bus commands
`define CMD_CFG_RD  4'hA
`define CMD_CFG_WR  4'hB
`define CMD_SPECIAL 4'h1

// Address field positions
`define FLD_TYPE    1:0
`define FLD_REG     7:2
`define FLD_FUNC    10:8
`define FLD_DEV     15:11
`define FLD_BUS     23:16
`define FLD_IDSEL   31:16
`define FLD_KEEP    10:2

// Field values
`define TYPE1_CODE  2'h1
`define TYPE0_CODE  2'h0
`define DEV_ALL1    5'h1F
`define FUNC_ALL1   3'h7
`define REG_ZERO    6'h00
`define DEV_CLEAR   5'h00
`define IDSEL_NONE  16'h0000
`define IDSEL_ONE   16'h0001

`endif

// >>> verilog/cfg_fwd_pkg.sv
// Types shared by the configuration forwarding block
package cfg_fwd_pkg;

    typedef enum logic [1:0] {PORT_PRI, PORT_S1, PORT_S2} port_t;

    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_HOLD} fsm_t;

    typedef enum logic [1:0] {END_NORMAL, END_RETRY, END_MABORT, END_TABORT} term_t;

    typedef struct packed {
        logic        valid;
        port_t       src;
        logic [31:0] addr;
        logic [3:0]  cmd;
        logic [31:0] data;
        logic        multi;
    } cfg_req_t;

    typedef struct packed {
        logic        valid;
        port_t       port;
        logic [31:0] addr;
        logic [3:0]  cmd;
        logic [31:0] data;
    } cfg_issue_t;

    typedef struct packed {
        logic        done;
        term_t       term;
        logic [31:0] data;
    } cfg_cpl_t;

    typedef struct packed {
        logic        valid;
        logic        claim;
        logic        retry;
        logic        trdy;
        logic        disc;
        logic        tabort;
        logic [31:0] data;
    } cfg_resp_t;

    typedef struct packed {
        logic [7:0] pri_bus;
        logic [7:0] s1_sec;
        logic [7:0] s1_sub;
        logic [7:0] s2_sec;
        logic [7:0] s2_sub;
    } bus_nums_t;

    typedef struct packed {
        fsm_t        fsm;
        cfg_req_t    held;
        cfg_issue_t  issue;
        logic        spc;
        term_t       res;
        logic [31:0] rdata;
        cfg_resp_t   resp;
        logic        rx_mabort;
    } state_t;

endpackage

// >>> sim/cfg_fwd_asserts.sv
// Port checker for the configuration forwarding block
`timescale 1ns/1ps
`default_nettype none
`include "cfg_fwd_defines.svh"
module cfg_fwd_asserts
(
    input wire logic                    clk_i,
    input wire logic                    reset_n_i,
    input wire cfg_fwd_pkg::cfg_req_t   req_i,
    input wire cfg_fwd_pkg::cfg_resp_t  resp_o,
    input wire cfg_fwd_pkg::cfg_issue_t issue_o,
    input wire cfg_fwd_pkg::cfg_cpl_t   cpl_i,
    input wire logic                    rx_mabort_o
);
    import cfg_fwd_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Finished target attempt, and an issued Type 0 form
    sequence s_done;
        cpl_i.done && issue_o.valid;
    endsequence
    sequence s_type0;
        issue_o.valid && issue_o.addr[1:0] == `TYPE0_CODE;
    endsequence
    chk_answer_next: assert property (req_i.valid |=> resp_o.valid)
        else $error("late answer");
    chk_type0_down: assert property (s_type0 |-> issue_o.port != PORT_PRI)
        else $error("Type 0 upstream");
    chk_type0_addr: assert property
        (s_type0 |-> issue_o.addr[15:11] == 5'h00 && $onehot0(issue_o.addr[31:16]))
        else $error("bad Type 0 address");
    chk_issue_hold: assert property (issue_o.valid [*2] |-> $stable(issue_o))
        else $error("issue moved");
    chk_slot_end: assert property
        (s_done |=> issue_o.valid == ($past(cpl_i.term) == END_RETRY))
        else $error("issue end wrong");
    chk_mabort_flag: assert property
        (s_done ##0 cpl_i.term == END_MABORT |=> rx_mabort_o == ($past(issue_o.cmd) != `CMD_SPECIAL))
        else $error("abort flag wrong");
    chk_mabort_cause: assert property
        (rx_mabort_o |-> $past(cpl_i.done && cpl_i.term == END_MABORT))
        else $error("stray abort flag");
    chk_disc_data: assert property (resp_o.disc |-> resp_o.trdy && resp_o.claim)
        else $error("bare disconnect");
    chk_spc_ignored: assert property
        (req_i.valid && req_i.cmd == `CMD_SPECIAL |=> !resp_o.claim)
        else $error("special claimed");
endmodule
bind cfg_fwd cfg_fwd_asserts u_chk (.clk_i, .reset_n_i, .req_i, .resp_o, .issue_o, .cpl_i, .rx_mabort_o);
`default_nettype wire

// >>> sim/cfg_target_model.sv
// Target-bus model that answers each issued attempt
`timescale 1ns/1ps
`default_nettype none
`include "cfg_fwd_defines.svh"
module cfg_target_model
(
    input  wire logic                    clk_i,
    input  wire logic                    reset_n_i,
    input  wire cfg_fwd_pkg::cfg_issue_t issue_i,
    input  wire cfg_fwd_pkg::term_t      term_i,
    input  wire logic [3:0]              delay_i,
    output var cfg_fwd_pkg::cfg_cpl_t    cpl_o
);
    import cfg_fwd_pkg::*;
    logic [3:0] cnt_q;
    logic       nosel;
    // Nobody claims a special cycle or a Type 0 with no select
    assign nosel = (issue_i.cmd == `CMD_SPECIAL) || ((issue_i.addr[31:16] == 16'h0000) && !issue_i.addr[0]);
    // Answer after delay_i waits; data churns so stale values never match
    always_ff @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i)
        begin
            cnt_q <= 4'h0;
            cpl_o <= '0;
        end
        else
        begin
            cpl_o.done <= 1'b0;
            cpl_o.data <= ~cpl_o.data;
            cnt_q <= (issue_i.valid && !cpl_o.done) ? cnt_q + 4'h1 : 4'h0;
            if (issue_i.valid && !cpl_o.done && cnt_q == delay_i)
                cpl_o <= '{1'b1, nosel ? END_MABORT : term_i, ~issue_i.addr};
        end
endmodule
`default_nettype wire

// >>> sim/cfg_fwd_test.sv
// Testbench for the configuration forwarding block
`timescale 1ns/1ps
`default_nettype none
`include "cfg_fwd_defines.svh"
module cfg_fwd_test;
    import cfg_fwd_pkg::*;
    logic       clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    cfg_req_t   req = '0;
    cfg_resp_t  resp, r;
    cfg_issue_t issue, iss;
    cfg_cpl_t   cpl;
    term_t      term = END_NORMAL;
    logic [3:0] dly = 4'h2;
    logic       rdy, mab, ms;
    int         num_errors = 0;
    int         n_tests = 0;
    cfg_fwd u_dut (.clk_i, .reset_n_i, .bus_nums_i(40'h0001040508), .req_i(req), .req_ready_o(rdy),
        .resp_o(resp), .issue_o(issue), .cpl_i(cpl), .rx_mabort_o(mab));
    cfg_target_model u_tgt (.clk_i, .reset_n_i, .issue_i(issue), .term_i(term), .delay_i(dly), .cpl_o(cpl));
    always #50 clk_i = ~clk_i;
    task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task print_verdict;
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One address phase; write data is the inverted address
    task automatic send(input port_t s, input logic [31:0] a, input logic [3:0] c, input logic m);
        @(posedge clk_i);
        #1 req = '{1'b1, s, a, c, ~a, m};
        @(posedge clk_i);
        #1 req.valid = 1'b0;
        r = resp;
    endtask
    // Whole delayed access: attempt, wait out the target bus, repeat
    task automatic xact(input port_t s, input logic [31:0] a, input logic [3:0] c, input logic m);
        int k;
        ms = 1'b0;
        send(s, a, c, m);
        iss = issue;
        for (k = 0; k < 60 && r.retry === 1'b1 && issue.valid !== 1'b0; k++)
        begin
            @(posedge clk_i);
            #1 ms = ms | mab;
        end
        cmp(k < 60, 1'b1);
        if (r.retry === 1'b1)
            send(s, a, c, m);
    endtask
    task automatic test_idsel;
        logic [31:0] a, e;
        for (int dv = 0; dv < 32; dv++)
        begin
            a = {8'h00, 8'h01, dv[4:0], 3'h2, 6'h05, 2'h1};
            e = {(dv < 16) ? 16'h0001 << dv : 16'h0000, 5'h00, a[10:2], 2'h0};
            dly = dv[3:0];
            xact(PORT_PRI, a, dv[0] ? `CMD_CFG_WR : `CMD_CFG_RD, 1'b0);
            cmp({iss.port, iss.addr}, {PORT_S1, e});
            if (dv < 16)
                cmp({r.claim, r.trdy, ms, r.data}, {3'b110, ~e});
            else
                cmp({r.valid, r.claim, ms}, 3'b101);
        end
    endtask
    task automatic test_type1;
        logic [31:0] a;
        a = {8'h00, 8'h02, 5'h03, 3'h1, 6'h04, 2'h1};
        dly = 4'h7;
        xact(PORT_PRI, a, `CMD_CFG_RD, 1'b0);
        cmp({iss.port, iss.cmd, iss.addr}, {PORT_S1, `CMD_CFG_RD, a});
        a[23:16] = 8'h08;
        xact(PORT_PRI, a, `CMD_CFG_WR, 1'b0);
        cmp({iss.port, iss.cmd, iss.addr, r.trdy}, {PORT_S2, `CMD_CFG_WR, a, 1'b1});
        a[23:16] = 8'h09;
        send(PORT_PRI, a, `CMD_CFG_RD, 1'b0);
        cmp({r.valid, r.claim, issue.valid}, 3'b100);
    endtask
    task automatic test_special;
        logic [31:0] a;
        a = {8'h00, 8'h01, 5'h1F, 3'h7, 6'h00, 2'h1};
        xact(PORT_PRI, a, `CMD_CFG_WR, 1'b1);
        cmp({iss.port, iss.cmd, ms, iss.addr}, {PORT_S1, `CMD_SPECIAL, 1'b0, a});
        cmp({r.claim, r.trdy, r.disc, iss.data}, {3'b111, ~a});
        a[23:16] = 8'h00;
        xact(PORT_S2, a, `CMD_CFG_WR, 1'b0);
        cmp({iss.port, iss.cmd, r.trdy}, {PORT_PRI, `CMD_SPECIAL, 1'b1});
        a[23:16] = 8'h30;
        a[7:2] = 6'h03;
        xact(PORT_S1, a, `CMD_CFG_WR, 1'b0);
        cmp({iss.port, iss.cmd, iss.addr}, {PORT_PRI, `CMD_CFG_WR, a});
        send(PORT_PRI, a, `CMD_SPECIAL, 1'b0);
        cmp({r.valid, r.claim, issue.valid}, 3'b100);
    endtask
    task automatic test_term;
        logic [31:0] a;
        a = {8'h00, 8'h01, 5'h02, 3'h0, 6'h09, 2'h1};
        term = END_RETRY;
        send(PORT_PRI, a, `CMD_CFG_WR, 1'b1);
        repeat (12) @(posedge clk_i);
        #1 cmp(issue.valid, 1'b1);
        term = END_NORMAL;
        xact(PORT_PRI, a, `CMD_CFG_WR, 1'b1);
        cmp({r.claim, r.trdy, r.disc}, 3'b111);
        term = END_TABORT;
        dly = 4'h0;
        xact(PORT_PRI, a ^ 32'h4, `CMD_CFG_RD, 1'b0);
        cmp({r.tabort, r.trdy}, 2'b10);
        cmp(rdy, 1'b1);
    endtask
    initial
    begin
        repeat (6) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        test_idsel;
        test_type1;
        test_special;
        test_term;
        print_verdict;
    end
    // Tests need under a thousand cycles; allow twenty thousand
    initial
    begin
        #2000000;
        num_errors++;
        print_verdict;
    end
endmodule
`default_nettype wire
